// *** src/tdm_mailbox.sv ***
// tdm_mailbox: block-code mailbox and point-address mapper of a telecontrol
// master, facing a controller that shares a word-addressed transfer file.
// assumes the controller port is synchronous to clk_sys_in, one access
// per cycle, and that the protocol engine sits behind the user-side ports.
`timescale 1ns/10ps
`default_nettype none
`include "tdm_map.svh"

// What this block does
// RQ1: double command value 1 is off, 2 on; 0 and 3 rejected.
// RQ2: step command value 1 lower, 2 higher; 0 and 3 rejected.
// RQ3: single command type 45 is one bit, 0 off and 1 on.
// RQ4: integrated totals are signed 32-bit double words.
// RQ5: float measurements type 13 and setpoints type 50 are IEEE single.
// RQ6: bitstring setpoint type 51 carries 32 independent bits.
// RQ7: single-point address: word is address/16, bit is remainder.
// RQ8: dual-point value is two adjacent bits at the bit address.
// RQ9: step point is a byte; even address is low byte of address/2.
// RQ10: normalized and scaled values use the address as word index.
// RQ11: double-word values start at word twice the address.
// RQ12: 9901 is a user command block, 9902 queues command-list entries.
// RQ13: 9970 copies module clock out, 9971 sets module clock.
// RQ14: 9903 marks event messages, 9950 command list error data.
// RQ15: status words 4000 to 4099 are kept updated by the device.
// RQ16: event block fills 4200 to 4299, then 9903 into 4200.
// RQ17: controller writes zero into 4200 once events are copied.
// RQ18: controller writes block codes to 4100, control area 4100-4199.
// RQ19: 9998 and 9999 both perform the same full restart.
// RQ20: user data at words 0 to 3999, higher words are block control.
// RQ21: after a command block the device clears 4100, no response.
// RQ22: unknown control codes are ignored and left in place.
// RQ23: no new event block while 4200 still holds 9903.
module tdm_mailbox
  import tdm_pkg::*;
#(
  parameter int unsigned ADDR_W = 13,
  parameter int unsigned EVT_WORDS = 100
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // controller access to the shared transfer file
  input wire logic ctl_wr_in,
  input wire logic [ADDR_W-1:0] ctl_addr_in,
  input wire logic [15:0] ctl_wdata_in,
  output logic [15:0] ctl_rdata_out,
  // status words supplied by the engine
  input wire logic [15:0] stat_word_in,
  output logic [6:0] stat_idx_out,
  // block-code requests to the engine
  output logic req_user_cmd_out,
  output logic req_list_cmd_out,
  output logic req_list_err_out,
  output logic req_clk_to_ctrl_out,
  output logic req_clk_from_ctrl_out,
  input wire logic req_done_in,
  output logic restart_out,
  // event block hand-over from the engine
  input wire logic evt_wr_in,
  input wire logic [6:0] evt_idx_in,
  input wire logic [15:0] evt_data_in,
  input wire logic evt_post_in,
  output logic evt_free_out,
  // point mapper
  input wire logic [2:0] map_kind_in,
  input wire logic [15:0] map_addr_in,
  output logic [11:0] map_word_out,
  output logic [3:0] map_bit_out,
  output logic [15:0] map_mask_out,
  // command value decoder
  input wire logic [7:0] cmd_type_in,
  input wire logic [1:0] cmd_val_in,
  output logic [1:0] cmd_action_out,
  output logic cmd_ok_out
);

  if (ADDR_W < 13 || EVT_WORDS != 100)
  begin : g_bad_param
    $error("tdm_mailbox: address must reach word 4299, event area 100");
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared transfer file storage
  logic [15:0] user_mem [0:3999]; // RQ20
  logic [15:0] ctrl_mem [0:99];
  logic [15:0] evt_mem [0:99];
  logic [15:0] ctrl_code_r, ctrl_code_nxt;
  logic [15:0] evt_code_r, evt_code_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  tdm_state_e state_r, state_nxt;
  logic [7:0] boot_cnt_r, boot_cnt_nxt;
  logic [6:0] stat_idx_r, stat_idx_nxt;
  logic [15:0] addr16;

  assign addr16 = 16'(ctl_addr_in);

  always_ff @(posedge clk_sys_in)
  begin
    if (ctl_wr_in && addr16 <= `TDM_USER_LAST)
      user_mem[addr16[11:0]] <= ctl_wdata_in; // RQ20
    if (ctl_wr_in && addr16 > `TDM_CTRL_FIRST && addr16 <= `TDM_CTRL_LAST)
      ctrl_mem[7'(addr16 - `TDM_CTRL_FIRST)] <= ctl_wdata_in;
    if (evt_wr_in && evt_free_out && evt_idx_in != 7'h00)
      evt_mem[evt_idx_in] <= evt_data_in; // RQ16
  end

  // status words are fetched by a rolling index, one per cycle
  always_comb
  begin
    stat_idx_nxt = (stat_idx_r == 7'd99) ? 7'h00 : stat_idx_r + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: status area mirrors engine state continuously
  logic [15:0] stat_mem [0:99];
  always_ff @(posedge clk_sys_in)
  begin
    stat_mem[stat_idx_r] <= stat_word_in; // RQ15
  end

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (addr16 <= `TDM_USER_LAST)
      rdata_nxt = user_mem[addr16[11:0]];
    else if (addr16 <= `TDM_STAT_LAST)
      rdata_nxt = stat_mem[7'(addr16 - `TDM_STAT_FIRST)]; // RQ15
    else if (addr16 == `TDM_CTRL_FIRST)
      rdata_nxt = ctrl_code_r;
    else if (addr16 <= `TDM_CTRL_LAST)
      rdata_nxt = ctrl_mem[7'(addr16 - `TDM_CTRL_FIRST)];
    else if (addr16 == `TDM_EVT_FIRST)
      rdata_nxt = evt_code_r;
    else if (addr16 <= `TDM_EVT_LAST)
      rdata_nxt = evt_mem[7'(addr16 - `TDM_EVT_FIRST)];
  end

  ////////////////////////////////////////////////////////////////////////////
  // control block-code interpreter
  logic code_known;
  always_comb
  begin
    case (ctrl_code_r)
      `TDM_BC_USER_CMD, `TDM_BC_LIST_CMD, `TDM_BC_LIST_ERR,
      `TDM_BC_CLK_TO_CTRL, `TDM_BC_CLK_FROM_CTRL,
      `TDM_BC_WARM_BOOT, `TDM_BC_COLD_BOOT:
        code_known = 1'b1;
      default:
        code_known = 1'b0; // RQ22
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    ctrl_code_nxt = ctrl_code_r;
    boot_cnt_nxt = boot_cnt_r;
    // 4100 takes a write only while idle with no known code about to start;
    // otherwise exec would begin on a code that raises no request and hang
    if (ctl_wr_in && addr16 == `TDM_CTRL_FIRST && state_r == TDM_ST_IDLE &&
        !code_known)
      ctrl_code_nxt = ctl_wdata_in; // RQ18
    case (state_r)
      TDM_ST_IDLE:
        if (code_known)
        begin
          if (ctrl_code_r == `TDM_BC_WARM_BOOT ||
              ctrl_code_r == `TDM_BC_COLD_BOOT)
          begin
            state_nxt = TDM_ST_BOOT; // RQ19
            boot_cnt_nxt = `TDM_BOOT_CYCLES;
          end
          else
            state_nxt = TDM_ST_EXEC; // RQ12 RQ13 RQ14
        end
      TDM_ST_EXEC:
        if (req_done_in)
          state_nxt = TDM_ST_CLEAR;
      TDM_ST_CLEAR:
      begin
        ctrl_code_nxt = 16'h0000; // RQ21
        state_nxt = TDM_ST_IDLE;
      end
      TDM_ST_BOOT:
        if (boot_cnt_r == 8'h00)
          state_nxt = TDM_ST_CLEAR;
        else
          boot_cnt_nxt = boot_cnt_r - 8'h01;
      default:
        state_nxt = TDM_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // event word: engine posts 9903, controller acknowledges with zero
  always_comb
  begin
    evt_code_nxt = evt_code_r;
    if (ctl_wr_in && addr16 == `TDM_EVT_FIRST && ctl_wdata_in == 16'h0000)
      evt_code_nxt = 16'h0000; // RQ17
    if (evt_post_in && evt_code_r != `TDM_BC_EVENT)
      evt_code_nxt = `TDM_BC_EVENT; // RQ16 RQ23
  end

  assign evt_free_out = (evt_code_r != `TDM_BC_EVENT); // RQ23

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || state_r == TDM_ST_BOOT)
    begin
      // a restart clears the event word, status index and read data whatever code caused it
      state_r <= (!rst_n_in) ? TDM_ST_IDLE : state_nxt;
      ctrl_code_r <= (!rst_n_in) ? 16'h0000 : ctrl_code_nxt;
      boot_cnt_r <= (!rst_n_in) ? 8'h00 : boot_cnt_nxt;
      evt_code_r <= 16'h0000; // RQ19
      stat_idx_r <= 7'h00;
      rdata_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      ctrl_code_r <= ctrl_code_nxt;
      boot_cnt_r <= boot_cnt_nxt;
      evt_code_r <= evt_code_nxt;
      stat_idx_r <= stat_idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign ctl_rdata_out = rdata_r;
  assign stat_idx_out = stat_idx_r;
  assign restart_out = (state_r == TDM_ST_BOOT); // RQ19
  assign req_user_cmd_out = (state_r == TDM_ST_EXEC) &&
                            (ctrl_code_r == `TDM_BC_USER_CMD); // RQ12
  assign req_list_cmd_out = (state_r == TDM_ST_EXEC) &&
                            (ctrl_code_r == `TDM_BC_LIST_CMD); // RQ12
  assign req_list_err_out = (state_r == TDM_ST_EXEC) &&
                            (ctrl_code_r == `TDM_BC_LIST_ERR); // RQ14
  assign req_clk_to_ctrl_out = (state_r == TDM_ST_EXEC) &&
                               (ctrl_code_r == `TDM_BC_CLK_TO_CTRL); // RQ13
  assign req_clk_from_ctrl_out = (state_r == TDM_ST_EXEC) &&
                                 (ctrl_code_r == `TDM_BC_CLK_FROM_CTRL); // RQ13

  ////////////////////////////////////////////////////////////////////////////
  // point address mapper
  // RQ4 RQ5 RQ6: 32-bit values (totals, floats, bitstrings) are stored raw
  // as two words; no reformatting, so sign and IEEE layout pass unchanged.
  always_comb
  begin
    map_word_out = 12'h000;
    map_bit_out = 4'h0;
    map_mask_out = 16'h0000;
    case (tdm_map_e'(map_kind_in))
      TDM_MAP_BIT:
      begin
        map_word_out = map_addr_in[15:4]; // RQ7
        map_bit_out = map_addr_in[3:0];
        map_mask_out = 16'h0001 << map_addr_in[3:0];
      end
      TDM_MAP_DUAL:
      begin
        map_word_out = map_addr_in[15:4]; // RQ8
        map_bit_out = map_addr_in[3:0];
        map_mask_out = 16'((17'h00003 << map_addr_in[3:0]));
      end
      TDM_MAP_BYTE:
      begin
        map_word_out = map_addr_in[12:1]; // RQ9
        map_bit_out = {map_addr_in[0], 3'b000};
        map_mask_out = map_addr_in[0] ? 16'hff00 : 16'h00ff;
      end
      TDM_MAP_WORD:
      begin
        map_word_out = map_addr_in[11:0]; // RQ10
        map_mask_out = 16'hffff;
      end
      TDM_MAP_DWORD:
      begin
        map_word_out = {map_addr_in[10:0], 1'b0}; // RQ11 RQ4 RQ5 RQ6
        map_mask_out = 16'hffff;
      end
      default:
        map_mask_out = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // command value decoder
  always_comb
  begin
    cmd_action_out = TDM_CV_REJECT;
    cmd_ok_out = 1'b0;
    case (cmd_type_in)
      `TDM_TYPE_SP_CMD:
      begin
        cmd_ok_out = ~cmd_val_in[1]; // RQ3
        if (cmd_ok_out)
          cmd_action_out = cmd_val_in[0] ? TDM_CV_ON_HIGH : TDM_CV_OFF_LOW;
      end
      `TDM_TYPE_DP_CMD, `TDM_TYPE_RS_CMD:
      begin
        cmd_ok_out = cmd_val_in[0] ^ cmd_val_in[1]; // RQ1 RQ2
        cmd_action_out = cmd_ok_out ? cmd_val_in : TDM_CV_REJECT;
      end
      default:
        cmd_ok_out = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_clear_after_done: assert property (@(posedge clk_sys_in) // RQ21
    disable iff (!rst_n_in) (state_r == TDM_ST_EXEC && req_done_in)
    |=> ##1 (ctrl_code_r == 16'h0000))
    else $error("control word not cleared after command");
  a_unknown_kept: assert property (@(posedge clk_sys_in) // RQ22
    disable iff (!rst_n_in) (state_r == TDM_ST_IDLE && !code_known &&
    !(ctl_wr_in && addr16 == `TDM_CTRL_FIRST)) |=> $stable(ctrl_code_r))
    else $error("unknown code changed");
  a_boot_restart: assert property (@(posedge clk_sys_in) // RQ19
    disable iff (!rst_n_in) (state_r == TDM_ST_IDLE && (ctrl_code_r ==
    `TDM_BC_WARM_BOOT || ctrl_code_r == `TDM_BC_COLD_BOOT))
    |=> restart_out)
    else $error("boot code did not restart");
  // a restart wipes the event word on purpose, so it is left out here
  a_event_hold: assert property (@(posedge clk_sys_in) // RQ23
    disable iff (!rst_n_in) (evt_code_r == `TDM_BC_EVENT &&
    state_r != TDM_ST_BOOT && !(ctl_wr_in && addr16 == `TDM_EVT_FIRST))
    |=> (evt_code_r == `TDM_BC_EVENT))
    else $error("event code dropped without ack");
  a_event_post: assert property (@(posedge clk_sys_in) // RQ16
    disable iff (!rst_n_in) (evt_post_in && evt_free_out && state_r !=
    TDM_ST_BOOT) |=> (evt_code_r == `TDM_BC_EVENT))
    else $error("event post not flagged");
  a_event_ack: assert property (@(posedge clk_sys_in) // RQ17
    disable iff (!rst_n_in) (ctl_wr_in && addr16 == `TDM_EVT_FIRST &&
    ctl_wdata_in == 16'h0000 && !evt_post_in) |=> evt_free_out)
    else $error("ack did not free event block");
  a_bit_map: assert property (@(posedge clk_sys_in) // RQ7
    disable iff (!rst_n_in) (map_kind_in == TDM_MAP_BIT) |->
    (16'(map_word_out) * 16'd16 + 16'(map_bit_out) == map_addr_in))
    else $error("bit address mapping wrong");
  a_dword_map: assert property (@(posedge clk_sys_in) // RQ11
    disable iff (!rst_n_in) (map_kind_in == TDM_MAP_DWORD &&
    map_addr_in < 16'd2048) |-> (16'(map_word_out) == 16'(map_addr_in * 2)))
    else $error("double word mapping wrong");
  a_double_reject: assert property (@(posedge clk_sys_in) // RQ1
    disable iff (!rst_n_in) (cmd_type_in == `TDM_TYPE_DP_CMD &&
    (cmd_val_in == 2'd0 || cmd_val_in == 2'd3)) |-> !cmd_ok_out)
    else $error("illegal double command accepted");
  a_step_ok: assert property (@(posedge clk_sys_in) // RQ2
    disable iff (!rst_n_in) (cmd_type_in == `TDM_TYPE_RS_CMD &&
    cmd_val_in == 2'd1) |-> (cmd_ok_out && cmd_action_out == 2'd1))
    else $error("step lower not decoded");

  c_user_cmd: cover property (@(posedge clk_sys_in) req_user_cmd_out);
  c_boot: cover property (@(posedge clk_sys_in) restart_out);
  c_event_cycle: cover property (@(posedge clk_sys_in)
    (evt_code_r == `TDM_BC_EVENT) ##[1:20] evt_free_out);

endmodule : tdm_mailbox
`default_nettype wire

// *** src/tdm_map.svh ***
// tdm_map.svh: word addresses, block codes and value encodings of the
// telecontrol data mailbox. assumes a 16-bit word-addressed transfer file.
`ifndef TDM_MAP_SVH
`define TDM_MAP_SVH

`define TDM_USER_LAST 16'd3999
`define TDM_STAT_FIRST 16'd4000
`define TDM_STAT_LAST 16'd4099
`define TDM_CTRL_FIRST 16'd4100
`define TDM_CTRL_LAST 16'd4199
`define TDM_EVT_FIRST 16'd4200
`define TDM_EVT_LAST 16'd4299

`define TDM_BC_USER_CMD 16'd9901
`define TDM_BC_LIST_CMD 16'd9902
`define TDM_BC_EVENT 16'd9903
`define TDM_BC_LIST_ERR 16'd9950
`define TDM_BC_CLK_TO_CTRL 16'd9970
`define TDM_BC_CLK_FROM_CTRL 16'd9971
`define TDM_BC_WARM_BOOT 16'd9998
`define TDM_BC_COLD_BOOT 16'd9999

`define TDM_TYPE_SP_CMD 8'd45
`define TDM_TYPE_DP_CMD 8'd46
`define TDM_TYPE_RS_CMD 8'd47
`define TDM_TYPE_FLOAT 8'd13
`define TDM_TYPE_FLOAT_CMD 8'd50
`define TDM_TYPE_BITS_CMD 8'd51

`define TDM_BOOT_CYCLES 8'd16

`endif

// *** src/tdm_pkg.sv ***
// tdm_pkg: types shared by the telecontrol data mailbox.
// assumes tdm_map.svh supplies the numbers.
package tdm_pkg;
  typedef enum logic [2:0] {
    TDM_ST_IDLE = 3'b000,
    TDM_ST_EXEC = 3'b001,
    TDM_ST_CLEAR = 3'b010,
    TDM_ST_BOOT = 3'b011
  } tdm_state_e;

  typedef enum logic [2:0] {
    TDM_MAP_BIT = 3'b000,
    TDM_MAP_DUAL = 3'b001,
    TDM_MAP_BYTE = 3'b010,
    TDM_MAP_WORD = 3'b011,
    TDM_MAP_DWORD = 3'b100
  } tdm_map_e;

  typedef enum logic [1:0] {
    TDM_CV_REJECT = 2'b00,
    TDM_CV_OFF_LOW = 2'b01,
    TDM_CV_ON_HIGH = 2'b10
  } tdm_cmdval_e;
endpackage : tdm_pkg

// *** verif/tdm_engine_model.sv ***
// tdm_engine_model: stand-in for the protocol engine behind the mailbox.
// assumes one request level at a time and a one-cycle done pulse.
`timescale 1ns/10ps
`default_nettype none

module tdm_engine_model
  import tdm_pkg::*;
#(
  parameter int unsigned DONE_DLY = 6
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // request side
  input wire logic [4:0] req_in,
  output logic req_done_out,
  // status side
  input wire logic [6:0] stat_idx_in,
  output logic [15:0] stat_word_out
);
  int cnt_r;

  // status word carries its own index so a stale slot shows up
  assign stat_word_out = 16'ha500 | {9'h0, stat_idx_in};

  // done only once per request; the level drops the cycle after
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 0;
      req_done_out <= 1'b0;
    end
    else
    begin
      req_done_out <= 1'b0;
      if (req_in != 5'h0 && !req_done_out)
      begin
        if (cnt_r == DONE_DLY)
        begin
          req_done_out <= 1'b1;
          cnt_r <= 0;
        end
        else
          cnt_r <= cnt_r + 1;
      end
      else
        cnt_r <= 0;
    end
  end
endmodule : tdm_engine_model

`default_nettype wire

// *** verif/tdm_mailbox_tb_top.sv ***
// tdm_mailbox_tb_top: self-checking bench for the mailbox.
// assumes the engine model answers requests and feeds status words.
`timescale 1ns/10ps
`default_nettype none
`include "tdm_map.svh"

module tdm_mailbox_tb_top
  import tdm_pkg::*;
;
  logic clk_sys_in, rst_n_in, ctl_wr, evt_wr, evt_post, restart;
  logic req_done, evt_free, cmd_ok;
  logic [12:0] ctl_addr;
  logic [15:0] ctl_wdata, rdata, stat_word, evt_data, map_addr;
  logic [15:0] map_mask, rd_val;
  logic [6:0] stat_idx, evt_idx;
  logic [2:0] map_kind;
  logic [11:0] map_word;
  logic [3:0] map_bit;
  logic [7:0] cmd_type;
  logic [1:0] cmd_val, cmd_action, ex;
  wire logic [4:0] req;
  int fail_count, check_count, n, m;
  logic [15:0] codes [5] = '{`TDM_BC_USER_CMD, `TDM_BC_LIST_CMD,
    `TDM_BC_LIST_ERR, `TDM_BC_CLK_TO_CTRL, `TDM_BC_CLK_FROM_CTRL};
  logic [2:0] mk [6] = '{TDM_MAP_BIT, TDM_MAP_DUAL, TDM_MAP_BYTE,
    TDM_MAP_BYTE, TDM_MAP_WORD, TDM_MAP_DWORD};
  logic [15:0] ma [6] = '{16'd1615, 16'd1601, 16'd200, 16'd201, 16'd100,
    16'd50};
  logic [15:0] mm [6] = '{16'h8000, 16'h0006, 16'h00ff, 16'hff00, 16'hffff,
    16'hffff};

  tdm_mailbox i_tdm_mailbox (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .ctl_wr_in(ctl_wr), .ctl_addr_in(ctl_addr), .ctl_wdata_in(ctl_wdata),
    .ctl_rdata_out(rdata), .stat_word_in(stat_word),
    .stat_idx_out(stat_idx), .req_user_cmd_out(req[4]),
    .req_list_cmd_out(req[3]), .req_list_err_out(req[2]),
    .req_clk_to_ctrl_out(req[1]), .req_clk_from_ctrl_out(req[0]),
    .req_done_in(req_done), .restart_out(restart), .evt_wr_in(evt_wr),
    .evt_idx_in(evt_idx), .evt_data_in(evt_data), .evt_post_in(evt_post),
    .evt_free_out(evt_free), .map_kind_in(map_kind),
    .map_addr_in(map_addr), .map_word_out(map_word),
    .map_bit_out(map_bit), .map_mask_out(map_mask),
    .cmd_type_in(cmd_type), .cmd_val_in(cmd_val),
    .cmd_action_out(cmd_action), .cmd_ok_out(cmd_ok));

  tdm_engine_model #(.DONE_DLY(6)) i_tdm_engine_model (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req),
    .req_done_out(req_done), .stat_idx_in(stat_idx),
    .stat_word_out(stat_word));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    ctl_wr <= 1'b1;
    ctl_addr <= a[12:0];
    ctl_wdata <= d;
    @(posedge clk_sys_in);
    ctl_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys_in);
    ctl_addr <= a[12:0];
    @(posedge clk_sys_in);
    #1;
    rd_val = rdata;
  endtask : rd

  // engine side: word write, or a post when p is set
  task automatic eng(input logic p, input logic [6:0] i,
    input logic [15:0] d);
    @(posedge clk_sys_in);
    evt_wr <= !p;
    evt_post <= p;
    evt_idx <= i;
    evt_data <= d;
    @(posedge clk_sys_in);
    evt_wr <= 1'b0;
    evt_post <= 1'b0;
  endtask : eng

  // bounded wait for req to reach the wanted emptiness
  task automatic wait_req(input logic busy);
    n = 0;
    while (((req != 5'h0) !== busy) && n < 40)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask : wait_req

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #750000;
    fail_count++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end

  initial
  begin
    rst_n_in <= 1'b0;
    ctl_wr <= 1'b0;
    ctl_addr <= 13'h0;
    ctl_wdata <= 16'h0;
    evt_wr <= 1'b0;
    evt_post <= 1'b0;
    evt_idx <= 7'h0;
    evt_data <= 16'h0;
    map_kind <= 3'h0;
    map_addr <= 16'h0;
    cmd_type <= 8'h0;
    cmd_val <= 2'h0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    chk({9'h0, evt_free, restart, req}, 16'h0040);
    // busy write to the control word must not survive the clear
    for (int k = 0; k < 5; k++)
    begin
      wr(16'd4100, codes[k]);
      wait_req(1'b1);
      chk({11'h0, req}, 16'h0010 >> k);
      wr(16'd4100, 16'd1234);
      wait_req(1'b0);
      repeat (3) @(posedge clk_sys_in);
      rd(16'd4100);
      chk(rd_val, 16'h0);
    end
    wr(16'd4100, 16'd1234);
    repeat (12) @(posedge clk_sys_in);
    #1;
    chk({11'h0, req, restart}, 16'h0);
    rd(16'd4100);
    chk(rd_val, 16'd1234);
    $display("test block codes done");
    eng(1'b0, 7'd1, 16'h0e01);
    eng(1'b0, 7'd3, 16'h0e03);
    eng(1'b1, 7'd0, 16'h0);
    rd(16'd4200);
    chk(rd_val, `TDM_BC_EVENT);
    chk({15'h0, evt_free}, 16'h0);
    rd(16'd4203);
    chk(rd_val, 16'h0e03);
    eng(1'b0, 7'd1, 16'hdead);
    wr(16'd4200, 16'd5);
    wr(16'd4201, 16'h1111);
    rd(16'd4201);
    chk(rd_val, 16'h0e01);
    rd(16'd4200);
    chk(rd_val, `TDM_BC_EVENT);
    wr(16'd4200, 16'h0);
    @(posedge clk_sys_in);
    #1;
    chk({15'h0, evt_free}, 16'h1);
    $display("test events done");
    // restart clears the control word after its fixed span
    for (int k = 0; k < 2; k++)
    begin
      wr(16'd4100, k ? `TDM_BC_COLD_BOOT : `TDM_BC_WARM_BOOT);
      n = 0;
      m = 0;
      while (restart !== 1'b1 && n < 10)
      begin
        @(posedge clk_sys_in);
        #1;
        n++;
      end
      while (restart === 1'b1 && m < 60)
      begin
        m++;
        @(posedge clk_sys_in);
        #1;
      end
      chk(m[15:0], {8'h0, `TDM_BOOT_CYCLES} + 16'd1);
      rd(16'd4100);
      chk(rd_val, 16'h0);
    end
    $display("test restart done");
    wr(16'd4005, 16'h1234);
    wr(16'd100, 16'h5678);
    wr(16'd101, 16'h9abc);
    wr(16'd3999, 16'h0f0f);
    repeat (110) @(posedge clk_sys_in);
    rd(16'd4000);
    chk(rd_val, 16'ha500);
    rd(16'd4005);
    chk(rd_val, 16'ha505);
    rd(16'd4099);
    chk(rd_val, 16'ha563);
    rd(16'd100);
    chk(rd_val, 16'h5678);
    rd(16'd101);
    chk(rd_val, 16'h9abc);
    rd(16'd3999);
    chk(rd_val, 16'h0f0f);
    $display("test file areas done");
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk_sys_in);
      map_kind <= mk[k];
      map_addr <= ma[k];
      @(posedge clk_sys_in);
      #1;
      chk({4'h0, map_word}, 16'd100);
      if (k < 2)
        chk({12'h0, map_bit}, {12'h0, ma[k][3:0]});
      chk(map_mask, mm[k]);
    end
    $display("test mapper done");
    // single command values above 1, and double and step values 0 and 3, must be refused
    for (int t = 0; t < 3; t++)
      for (int v = 0; v < 4; v++)
      begin
        if (t == 0)
          ex = (v < 2) ? 2'(v + 1) : 2'd0;
        else
          ex = (v == 1 || v == 2) ? 2'(v) : 2'd0;
        @(posedge clk_sys_in);
        cmd_type <= (t == 0) ? `TDM_TYPE_SP_CMD :
          (t == 1) ? `TDM_TYPE_DP_CMD : `TDM_TYPE_RS_CMD;
        cmd_val <= v[1:0];
        @(posedge clk_sys_in);
        #1;
        chk({13'h0, cmd_ok, cmd_action}, {13'h0, ex != 0, ex});
      end
    $display("test commands done");
    report_and_stop();
  end
endmodule : tdm_mailbox_tb_top

`default_nettype wire
